// ### ics_pkg.sv
// Shared constants and types for the input clock selector
package ics_pkg;

   // Register indices (word address on the bus)
   localparam logic [11:0] IDX_FORCE_HOLD = 12'h736;
   localparam logic [11:0] IDX_SWITCH     = 12'h737;
   localparam logic [11:0] IDX_MASKS      = 12'h738;
   localparam logic [11:0] IDX_PRIO01     = 12'h739;
   localparam logic [11:0] IDX_PRIO23     = 12'h73a;
   localparam logic [11:0] IDX_MANUAL_SEL = 12'h73f;
   localparam logic [11:0] IDX_STATUS     = 12'h741;

   // Field positions
   localparam int POS_FORCE   = 0;
   localparam int POS_MODE    = 0;
   localparam int POS_HSW     = 2;
   localparam int POS_LOS     = 0;
   localparam int POS_OOF     = 4;
   localparam int POS_RANK_LO = 0;
   localparam int POS_RANK_HI = 4;

   // Writable bits of each register
   localparam logic [7:0] MSK_FORCE  = 8'h01;
   localparam logic [7:0] MSK_SWITCH = 8'h07;
   localparam logic [7:0] MSK_MASKS  = 8'hff;
   localparam logic [7:0] MSK_PRIO   = 8'h77;
   localparam logic [7:0] MSK_MANUAL = 8'h07;

   // Reset values
   localparam logic [7:0] RST_FORCE  = 8'h00;
   localparam logic [7:0] RST_SWITCH = 8'h00;
   localparam logic [7:0] RST_MASKS  = 8'h00;
   localparam logic [7:0] RST_PRIO   = 8'h00;
   localparam logic [7:0] RST_MANUAL = 8'h00;

   // Rank limits and input numbering
   localparam logic [2:0] MAX_RANK_ZERO_ONE  = 3'h3;
   localparam logic [2:0] MAX_RANK_TWO_THREE = 3'h4;
   localparam logic [2:0] SEL_MAX            = 3'h4;
   localparam logic [2:0] SEL_FIRST_MANUAL   = 3'h3;

   typedef enum logic [1:0] {
      MODE_MANUAL      = 2'b00,
      MODE_AUTO_NONREV = 2'b01,
      MODE_AUTO_REV    = 2'b10,
      MODE_RESERVED    = 2'b11
   } ics_mode_t;

   typedef enum logic [1:0] {
      ST_MANUAL     = 2'b00,
      ST_AUTO_TRACK = 2'b01,
      ST_AUTO_HOLD  = 2'b10
   } ics_state_t;

endpackage : ics_pkg

// ### ics_alarm_qual.sv
// Alarm synchroniser and mask qualifier for the four reference inputs
`timescale 1ns/1ps
module ics_alarm_qual (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Raw alarms from the detectors
   input  wire logic [3:0] i_los,
   input  wire logic [3:0] i_oof,
   // Masks, 1 hides the alarm
   input  wire logic [3:0] i_los_mask,
   input  wire logic [3:0] i_oof_mask,
   // Inputs free of unmasked alarms
   output logic      [3:0] o_usable
);

   logic [3:0] los_meta;
   logic [3:0] los_sync;
   logic [3:0] oof_meta;
   logic [3:0] oof_sync;
   logic [3:0] usable_reg;
   logic [3:0] usable_next;

   genvar n;
   for (n = 0; n < 4; n++) begin : g_in
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            los_meta[n] <= 1'b0;
            los_sync[n] <= 1'b0;
            oof_meta[n] <= 1'b0;
            oof_sync[n] <= 1'b0;
         end else begin
            los_meta[n] <= i_los[n];
            los_sync[n] <= los_meta[n];
            oof_meta[n] <= i_oof[n];
            oof_sync[n] <= oof_meta[n];
         end
      end

      assign usable_next[n] = ~(los_sync[n] & ~i_los_mask[n])
                            & ~(oof_sync[n] & ~i_oof_mask[n]);

      property p_los_gate;
         @(posedge i_clk) disable iff (i_rst)
         (los_sync[n] && !i_los_mask[n]) |=> !o_usable[n];
      endproperty
      a_los_gate: assert property (p_los_gate) else $error("unmasked loss alarm left input usable");

      property p_oof_gate;
         @(posedge i_clk) disable iff (i_rst)
         (oof_sync[n] && !i_oof_mask[n]) |=> !o_usable[n];
      endproperty
      a_oof_gate: assert property (p_oof_gate) else $error("unmasked offset alarm left input usable");

      property p_mask_hides;
         @(posedge i_clk) disable iff (i_rst)
         (i_los_mask[n] && i_oof_mask[n]) |=> o_usable[n];
      endproperty
      a_mask_hides: assert property (p_mask_hides) else $error("fully masked input not usable");
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         usable_reg <= 4'hf;
      end else begin
         usable_reg <= usable_next;
      end
   end

   assign o_usable = usable_reg;

endmodule : ics_alarm_qual

// ### ics_rank_pick.sv
// Priority picker over the automatically selectable inputs
`timescale 1ns/1ps
module ics_rank_pick (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Rank fields, input zero in the low bits
   input  wire logic [8:0] i_rank,
   input  wire logic [2:0] i_usable,
   // Result
   output logic      [2:0] o_cand_ok,
   output logic      [1:0] o_best_idx,
   output logic            o_best_valid
);

   logic [2:0] ok_c;
   logic [2:0] cand_reg;
   logic [1:0] best_idx_reg;
   logic [1:0] best_idx_next;
   logic       best_valid_reg;
   logic       best_valid_next;
   logic [2:0] best_rank;

   genvar e;
   for (e = 0; e < 3; e++) begin : g_ent
      localparam logic [2:0] LIM = (e == 2) ? ics_pkg::MAX_RANK_TWO_THREE
                                            : ics_pkg::MAX_RANK_ZERO_ONE;
      // Zero excludes; values above the limit are reserved and also exclude
      assign ok_c[e] = i_usable[e] && (i_rank[3*e +: 3] != 3'h0)
                    && (i_rank[3*e +: 3] <= LIM);

      property p_reserved_excluded;
         @(posedge i_clk) disable iff (i_rst)
         (i_rank[3*e +: 3] > LIM || i_rank[3*e +: 3] == 3'h0) |=> !o_cand_ok[e];
      endproperty
      a_reserved_excluded: assert property (p_reserved_excluded) else $error("excluded rank chosen");
   end

   // Lower rank wins; on a tie the lower input number wins
   always_comb begin
      best_idx_next   = 2'h0;
      best_valid_next = 1'b0;
      best_rank       = 3'h7;
      for (int k = 0; k < 3; k++) begin
         if (ok_c[k] && (!best_valid_next || i_rank[3*k +: 3] < best_rank)) begin
            best_valid_next = 1'b1;
            best_rank       = i_rank[3*k +: 3];
            best_idx_next   = 2'(k);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cand_reg       <= 3'h0;
         best_idx_reg   <= 2'h0;
         best_valid_reg <= 1'b0;
      end else begin
         cand_reg       <= ok_c;
         best_idx_reg   <= best_idx_next;
         best_valid_reg <= best_valid_next;
      end
   end

   assign o_cand_ok    = cand_reg;
   assign o_best_idx   = best_idx_reg;
   assign o_best_valid = best_valid_reg;

   property p_valid_any;
      @(posedge i_clk) disable iff (i_rst)
      o_best_valid == (|o_cand_ok);
   endproperty
   a_valid_any: assert property (p_valid_any) else $error("best valid disagrees with candidates");

endmodule : ics_rank_pick

// ### ics_input_selector.sv
// Input clock selector and holdover control for the fourth loop
`timescale 1ns/1ps
module ics_input_selector (
   // Clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   // Avalon-MM slave, word addressed
   input  wire logic [11:0] I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   // Alarms from the input detectors
   input  wire logic [3:0]  I_SIGNAL_LOSS_ALARM,
   input  wire logic [3:0]  I_FREQ_OFFSET_ALARM,
   // Loop control
   output logic      [2:0]  O_SELECTED_INPUT,
   output logic             O_HOLDOVER,
   output logic             O_PHASE_BUILDOUT_EN,
   output logic             O_SWITCH_PULSE
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0]  force_reg;
   logic [7:0]  force_next;
   logic [7:0]  switch_reg;
   logic [7:0]  switch_next;
   logic [7:0]  masks_reg;
   logic [7:0]  masks_next;
   logic [7:0]  prio01_reg;
   logic [7:0]  prio01_next;
   logic [7:0]  prio23_reg;
   logic [7:0]  prio23_next;
   logic [7:0]  manual_reg;
   logic [7:0]  manual_next;

   logic        ack_reg;
   logic        ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        req;
   logic        wr_en;
   logic [7:0]  status_byte;

   ics_pkg::ics_mode_t  mode;
   logic                mode_auto;
   logic [3:0]          usable;
   logic [2:0]          cand_ok;
   logic [3:0]          cand_ext;
   logic [1:0]          best_idx;
   logic                best_valid;
   logic [2:0]          man_sel;
   logic                man_lost;
   logic                cur_ok;

   ics_pkg::ics_state_t state_reg;
   ics_pkg::ics_state_t state_next;
   logic [2:0]          sel_reg;
   logic [2:0]          sel_next;
   logic                hold_reg;
   logic                hold_next;
   logic                pulse_reg;
   logic                pulse_next;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then the access completes

   assign req               = I_AVS_READ | I_AVS_WRITE;
   assign O_AVS_WAITREQUEST = req & ~ack_reg;
   assign wr_en             = I_AVS_WRITE & ack_reg & I_AVS_BYTEENABLE[0];
   assign status_byte       = {usable, hold_reg, sel_reg};

   always_comb begin
      ack_next   = req & ~ack_reg;
      rdata_next = rdata_reg;
      if (I_AVS_READ && !ack_reg) begin
         case (I_AVS_ADDRESS)
            ics_pkg::IDX_FORCE_HOLD: rdata_next = {24'h000000, force_reg};
            ics_pkg::IDX_SWITCH:     rdata_next = {24'h000000, switch_reg};
            ics_pkg::IDX_MASKS:      rdata_next = {24'h000000, masks_reg};
            ics_pkg::IDX_PRIO01:     rdata_next = {24'h000000, prio01_reg};
            ics_pkg::IDX_PRIO23:     rdata_next = {24'h000000, prio23_reg};
            ics_pkg::IDX_MANUAL_SEL: rdata_next = {24'h000000, manual_reg};
            ics_pkg::IDX_STATUS:     rdata_next = {24'h000000, status_byte};
            default:                 rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign O_AVS_READDATA = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; unmapped and status writes are dropped

   always_comb begin
      force_next  = force_reg;
      switch_next = switch_reg;
      masks_next  = masks_reg;
      prio01_next = prio01_reg;
      prio23_next = prio23_reg;
      manual_next = manual_reg;
      if (wr_en) begin
         case (I_AVS_ADDRESS)
            ics_pkg::IDX_FORCE_HOLD: force_next  = I_AVS_WRITEDATA[7:0] & ics_pkg::MSK_FORCE;
            ics_pkg::IDX_SWITCH:     switch_next = I_AVS_WRITEDATA[7:0] & ics_pkg::MSK_SWITCH;
            ics_pkg::IDX_MASKS:      masks_next  = I_AVS_WRITEDATA[7:0] & ics_pkg::MSK_MASKS;
            ics_pkg::IDX_PRIO01:     prio01_next = I_AVS_WRITEDATA[7:0] & ics_pkg::MSK_PRIO;
            ics_pkg::IDX_PRIO23:     prio23_next = I_AVS_WRITEDATA[7:0] & ics_pkg::MSK_PRIO;
            ics_pkg::IDX_MANUAL_SEL: manual_next = I_AVS_WRITEDATA[7:0] & ics_pkg::MSK_MANUAL;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         force_reg  <= ics_pkg::RST_FORCE;
         switch_reg <= ics_pkg::RST_SWITCH;
         masks_reg  <= ics_pkg::RST_MASKS;
         prio01_reg <= ics_pkg::RST_PRIO;
         prio23_reg <= ics_pkg::RST_PRIO;
         manual_reg <= ics_pkg::RST_MANUAL;
      end else begin
         force_reg  <= force_next;
         switch_reg <= switch_next;
         masks_reg  <= masks_next;
         prio01_reg <= prio01_next;
         prio23_reg <= prio23_next;
         manual_reg <= manual_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm qualification and priority search

   ics_alarm_qual u_alarm (
      .i_clk      (I_CLK_SYS),
      .i_rst      (I_RST),
      .i_los      (I_SIGNAL_LOSS_ALARM),
      .i_oof      (I_FREQ_OFFSET_ALARM),
      .i_los_mask (masks_reg[ics_pkg::POS_LOS +: 4]),
      .i_oof_mask (masks_reg[ics_pkg::POS_OOF +: 4]),
      .o_usable   (usable)
   );

   // Input three's rank is stored but never searched: it is manual only
   ics_rank_pick u_pick (
      .i_clk        (I_CLK_SYS),
      .i_rst        (I_RST),
      .i_rank       ({prio23_reg[ics_pkg::POS_RANK_LO +: 3],
                      prio01_reg[ics_pkg::POS_RANK_HI +: 3],
                      prio01_reg[ics_pkg::POS_RANK_LO +: 3]}),
      .i_usable     (usable[2:0]),
      .o_cand_ok    (cand_ok),
      .o_best_idx   (best_idx),
      .o_best_valid (best_valid)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Selection state machine

   assign mode      = ics_pkg::ics_mode_t'(switch_reg[ics_pkg::POS_MODE +: 2]);
   assign mode_auto = (mode == ics_pkg::MODE_AUTO_NONREV) || (mode == ics_pkg::MODE_AUTO_REV);
   assign man_sel   = manual_reg[2:0];
   assign cand_ext  = {1'b0, cand_ok};
   assign cur_ok    = (sel_reg < ics_pkg::SEL_FIRST_MANUAL) && cand_ext[sel_reg[1:0]];
   // Input four has no alarm detector, so it never reads as lost
   assign man_lost  = (sel_reg < ics_pkg::SEL_MAX) && !usable[sel_reg[1:0]];

   always_comb begin
      state_next = state_reg;
      sel_next   = sel_reg;
      case (state_reg)
         ics_pkg::ST_MANUAL: begin
            if (mode_auto) begin
               if (best_valid) begin
                  state_next = ics_pkg::ST_AUTO_TRACK;
                  sel_next   = {1'b0, best_idx};
               end else begin
                  state_next = ics_pkg::ST_AUTO_HOLD;
               end
            end else if (man_sel <= ics_pkg::SEL_MAX) begin
               // Ranks are not consulted here; out-of-range picks are ignored
               sel_next = man_sel;
            end
         end
         ics_pkg::ST_AUTO_TRACK: begin
            if (!mode_auto) begin
               state_next = ics_pkg::ST_MANUAL;
            end else if (mode == ics_pkg::MODE_AUTO_NONREV && cur_ok) begin
               sel_next = sel_reg;
            end else if (best_valid) begin
               sel_next = {1'b0, best_idx};
            end else begin
               state_next = ics_pkg::ST_AUTO_HOLD;
            end
         end
         ics_pkg::ST_AUTO_HOLD: begin
            if (!mode_auto) begin
               state_next = ics_pkg::ST_MANUAL;
            end else if (best_valid) begin
               state_next = ics_pkg::ST_AUTO_TRACK;
               sel_next   = {1'b0, best_idx};
            end
         end
         default: begin
            state_next = ics_pkg::ST_MANUAL;
         end
      endcase
   end

   always_comb begin
      hold_next = force_reg[ics_pkg::POS_FORCE]
                | (state_reg == ics_pkg::ST_AUTO_HOLD)
                | ((state_reg == ics_pkg::ST_MANUAL) && man_lost);
      pulse_next = (sel_next != sel_reg);
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         state_reg <= ics_pkg::ST_MANUAL;
         sel_reg   <= 3'h0;
         hold_reg  <= 1'b0;
         pulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         sel_reg   <= sel_next;
         hold_reg  <= hold_next;
         pulse_reg <= pulse_next;
      end
   end

   assign O_SELECTED_INPUT    = sel_reg;
   assign O_HOLDOVER          = hold_reg;
   // Hitless switching runs with phase buildout, glitchless without
   assign O_PHASE_BUILDOUT_EN = switch_reg[ics_pkg::POS_HSW];
   assign O_SWITCH_PULSE      = pulse_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_force_hold;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      force_reg[ics_pkg::POS_FORCE] |=> O_HOLDOVER;
   endproperty
   a_force_hold: assert property (p_force_hold) else $error("force bit did not hold the loop");

   property p_hold_cause;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      O_HOLDOVER |-> $past(force_reg[ics_pkg::POS_FORCE])
                  || $past(state_reg) == ics_pkg::ST_AUTO_HOLD
                  || ($past(state_reg) == ics_pkg::ST_MANUAL && $past(man_lost));
   endproperty
   a_hold_cause: assert property (p_hold_cause) else $error("holdover without a cause");

   property p_manual_mode;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      !mode_auto |=> state_reg == ics_pkg::ST_MANUAL;
   endproperty
   a_manual_mode: assert property (p_manual_mode) else $error("manual or reserved mode left manual");

   property p_auto_low_only;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      state_reg == ics_pkg::ST_AUTO_TRACK |-> sel_reg < ics_pkg::SEL_FIRST_MANUAL;
   endproperty
   a_auto_low_only: assert property (p_auto_low_only) else $error("automatic pick of manual-only input");

   property p_style_write;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (wr_en && I_AVS_ADDRESS == ics_pkg::IDX_SWITCH)
         |=> O_PHASE_BUILDOUT_EN == $past(I_AVS_WRITEDATA[ics_pkg::POS_HSW]);
   endproperty
   a_style_write: assert property (p_style_write) else $error("switching style not applied");

   property p_manual_follow;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (state_reg == ics_pkg::ST_MANUAL && !mode_auto && man_sel <= ics_pkg::SEL_MAX)
         |=> O_SELECTED_INPUT == $past(man_sel)
             && O_SWITCH_PULSE == ($past(man_sel) != $past(O_SELECTED_INPUT));
   endproperty
   a_manual_follow: assert property (p_manual_follow) else $error("manual pick not followed");

   property p_revert;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (state_reg == ics_pkg::ST_AUTO_TRACK && mode == ics_pkg::MODE_AUTO_REV && best_valid)
         |=> O_SELECTED_INPUT == {1'b0, $past(best_idx)};
   endproperty
   a_revert: assert property (p_revert) else $error("revertive mode not on best input");

   property p_no_clean;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (mode_auto && !best_valid) |=> state_reg == ics_pkg::ST_AUTO_HOLD ##1 O_HOLDOVER;
   endproperty
   a_no_clean: assert property (p_no_clean) else $error("no clean input but no holdover");

   // Non-revertive: a clean current input is never left for a better one
   property p_nonrev_keep;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (state_reg == ics_pkg::ST_AUTO_TRACK && mode == ics_pkg::MODE_AUTO_NONREV && cur_ok)
         |=> O_SELECTED_INPUT == $past(O_SELECTED_INPUT);
   endproperty
   a_nonrev_keep: assert property (p_nonrev_keep) else $error("non-revertive mode left a clean input");

   // Tracking a clean input keeps the loop out of holdover unless forced
   property p_track_no_hold;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      (state_reg == ics_pkg::ST_AUTO_TRACK && !force_reg[ics_pkg::POS_FORCE]) |=> !O_HOLDOVER;
   endproperty
   a_track_no_hold: assert property (p_track_no_hold) else $error("holdover while tracking a clean input");

   // The pulse marks exactly the cycles in which the selection moved
   property p_pulse_change;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      O_SWITCH_PULSE == (O_SELECTED_INPUT != $past(O_SELECTED_INPUT));
   endproperty
   a_pulse_change: assert property (p_pulse_change) else $error("switch pulse disagrees with selection");

   property p_wait_one;
      @(posedge I_CLK_SYS) disable iff (I_RST)
      ($rose(req) || (req && $past(ack_reg))) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait cycle");

endmodule : ics_input_selector

// ### ics_ref_model.sv
// Alarm detector model for the four reference inputs
`timescale 1ns/1ps
module ics_ref_model (
   // Clock
   input  wire logic       i_clk,
   // Alarm levels requested by the bench
   input  wire logic [3:0] i_los_req,
   input  wire logic [3:0] i_oof_req,
   // Detector outputs
   output logic      [3:0] o_los,
   output logic      [3:0] o_oof
);
   initial begin
      o_los = 4'h0;
      o_oof = 4'h0;
   end
   // Detectors report one cycle late, as a qualifying detector would
   always @(posedge i_clk) begin
      o_los <= i_los_req;
      o_oof <= i_oof_req;
   end
endmodule : ics_ref_model

// ### ics_input_selector_tb.sv
// Self-checking bench for the input clock selector
`timescale 1ns/1ps
module ics_input_selector_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] addr = 12'h000;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  be = 4'h1;
   logic [31:0] rdata;
   logic        waitreq;
   logic [3:0]  los_req = 4'h0;
   logic [3:0]  oof_req = 4'h0;
   logic [3:0]  signal_loss_alarm;
   logic [3:0]  freq_offset_alarm;
   logic [2:0]  sel;
   logic        hold;
   logic        pbo;
   logic        pulse;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          pulses = 0;
   logic [31:0] seed = 32'd48;
   logic [11:0] regs [5] = '{12'h736, 12'h737, 12'h738, 12'h739, 12'h73a};
   logic [7:0]  msks [5] = '{8'h01, 8'h07, 8'hff, 8'h77, 8'h77};

   always #2 clk = ~clk;

   ics_ref_model u_ics_ref_model (.i_clk(clk), .i_los_req(los_req), .i_oof_req(oof_req), .o_los(signal_loss_alarm), .o_oof(freq_offset_alarm));

   ics_input_selector u_ics_input_selector (
      .I_CLK_SYS(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
      .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
      .I_SIGNAL_LOSS_ALARM(signal_loss_alarm), .I_FREQ_OFFSET_ALARM(freq_offset_alarm), .O_SELECTED_INPUT(sel), .O_HOLDOVER(hold),
      .O_PHASE_BUILDOUT_EN(pbo), .O_SWITCH_PULSE(pulse));

   ////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // Ceiling sits well above the roughly 1200 cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (pulse === 1'b1) pulses <= pulses + 1;
      if (cycles == 8000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [3:0] usable(input logic [3:0] l, input logic [3:0] o, input logic [7:0] m);
      return ~((l & ~m[3:0]) | (o & ~m[7:4]));
   endfunction : usable

   // Best clean ranked input among zero to two, 7 when none is left
   function automatic logic [2:0] pick(input logic [7:0] p01, input logic [7:0] p23, input logic [3:0] us);
      logic [2:0] r;
      logic [2:0] best;
      logic [2:0] br;
      best = 3'h7;
      br = 3'h7;
      for (int i = 0; i < 3; i++) begin
         r = (i == 0) ? p01[2:0] : (i == 1) ? p01[6:4] : p23[2:0];
         if (us[i] && r != 3'h0 && r <= ((i < 2) ? 3'h3 : 3'h4) && r < br) begin
            br = r;
            best = 3'(i);
         end
      end
      return best;
   endfunction : pick

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      do @(posedge clk); while (waitreq !== 1'b0);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic wr8(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr8

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rd_chk

   task settle;
      repeat (10) @(posedge clk);
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] p01;
      logic [7:0] p23;
      logic [7:0] m;
      logic [7:0] q;
      logic [3:0] l;
      logic [3:0] o;
      logic [3:0] us;
      logic [2:0] e;
      logic [31:0] rv;
      int base;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         rd_chk(regs[k], 8'h00);
         rv = xs();
         wr8(regs[k], rv[7:0]);
         rd_chk(regs[k], rv[7:0] & msks[k]);
         wr8(regs[k], 8'h00);
      end
      wr8(12'h700, 8'h5a);
      rd_chk(12'h700, 8'h00);
      be <= 4'h0;
      wr8(12'h736, 8'h01);
      be <= 4'h1;
      rd_chk(12'h736, 8'h00);
      wr8(12'h736, 8'h01);
      settle();
      chk(hold, 1'b1);
      wr8(12'h736, 8'h00);
      settle();
      chk(hold, 1'b0);
      wr8(12'h737, 8'h04);
      settle();
      chk(pbo, 1'b1);
      wr8(12'h737, 8'h00);
      settle();
      chk(pbo, 1'b0);
      // Manual mode: ranks present but ignored
      wr8(12'h739, 8'h11);
      wr8(12'h73f, 8'h03);
      settle();
      chk(sel, 3'h3);
      // Out-of-range manual pick leaves the selection alone
      wr8(12'h73f, 8'h05);
      settle();
      chk(sel, 3'h3);
      wr8(12'h73f, 8'h04);
      wr8(12'h737, 8'h03);
      settle();
      chk(sel, 3'h4);
      wr8(12'h737, 8'h00);
      wr8(12'h73f, 8'h01);
      los_req <= 4'h2;
      settle();
      chk(hold, 1'b1);
      los_req <= 4'h0;
      wr8(12'h73f, 8'h00);
      // Non-revertive stays put after the better input clears
      wr8(12'h739, 8'h21);
      wr8(12'h737, 8'h01);
      settle();
      chk(sel, 3'h0);
      base = pulses;
      los_req <= 4'h1;
      settle();
      chk(sel, 3'h1);
      chk(32'(pulses - base), 32'h1);
      los_req <= 4'h0;
      settle();
      chk(sel, 3'h1);
      wr8(12'h737, 8'h02);
      settle();
      chk(sel, 3'h0);
      los_req <= 4'h1;
      wr8(12'h738, 8'h01);
      settle();
      chk(sel, 3'h0);
      los_req <= 4'h0;
      oof_req <= 4'h1;
      wr8(12'h738, 8'h10);
      settle();
      chk(sel, 3'h0);
      wr8(12'h738, 8'h00);
      settle();
      chk(sel, 3'h1);
      // Random ranks, masks and alarms in revertive mode; input three always ranked
      for (int n = 0; n < 40; n++) begin
         rv = xs();
         p01 = rv[7:0] & 8'h77;
         p23 = (rv[15:8] & 8'h07) | 8'h10;
         m = rv[23:16] & rv[31:24];
         rv = xs();
         l = rv[3:0] & rv[7:4];
         o = rv[11:8] & rv[15:12];
         us = usable(l, o, m);
         los_req <= l;
         oof_req <= o;
         wr8(12'h739, p01);
         wr8(12'h73a, p23);
         wr8(12'h738, m);
         settle();
         e = pick(p01, p23, us);
         if (e == 3'h7) begin
            chk(hold, 1'b1);
         end else begin
            chk(sel, e);
            chk(hold, 1'b0);
         end
         bus(1'b0, 12'h741, 8'h00, q);
         chk(q[7:4], us);
      end
      // Mid-run reset returns registers and outputs to their idle values
      los_req <= 4'h0;
      oof_req <= 4'h0;
      wr8(12'h737, 8'h06);
      wr8(12'h736, 8'h01);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({sel, hold, pbo, pulse}, 6'h00);
      rd_chk(12'h736, 8'h00);
      rd_chk(12'h737, 8'h00);
      tally_and_finish();
   end
endmodule : ics_input_selector_tb
